// ---- logic/prom_program_control.sv ----
// Purpose: apb slave for the prom programming control register and a 4k prom array
// Assumes: single clock, zero-wait apb slave
// Notes: control at byte 0x0ec, status at 0x0f0, array byte i at 0x4000 + 4*i
// Summary of operation
// - reset clears control register; normal reads, programming power off.
// - latch enabled: array writes capture address and data unless burning; array reads blocked.
// - latch disabled: normal reads, no location can be programmed.
// - power command bit only writable while latch enable is set.
// - power command bit switches programming power onto the array.
// - bits 6, 2, 1 always read zero.
// - test bits stored but have no normal-mode function; software keeps zero.
// - array changes only when programming high voltage is present.
// - erased location reads back ff.
// - programming allowed only in special test and bootstrap modes.
// - programming only clears bits, byte at a time, any order.
`timescale 1ns/1ps
`default_nettype none
`include "prom_program_control_params.svh"
module prom_program_control (
  // apb clock and reset
  input  wire  logic                   pclk,
  input  wire  logic                   presetn,
  // apb slave
  input  wire  logic                   psel,
  input  wire  logic                   penable,
  input  wire  logic                   pwrite,
  input  wire  logic [`PADDR_W-1:0]    paddr,
  input  wire  logic [31:0]            pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  // device context
  input  wire  logic                   special_mode,
  input  wire  logic                   prom_present_enable,
  input  wire  logic                   vpp_high_voltage,
  // programming status
  output logic                         program_power_on
);
  prom_program_control_pkg::byte_t       ctrl;
  prom_program_control_pkg::byte_t       next_ctrl;
  prom_program_control_pkg::byte_t       latch_data;
  logic [`ARRAY_AW-1:0]                  latch_addr;
  logic                                  latch_valid;
  prom_program_control_pkg::byte_t       mem [0:`ARRAY_WORDS-1];
  prom_program_control_pkg::prom_state_e state;

  logic                 access;
  logic                 wr;
  logic                 rd;
  logic                 hit_ctrl;
  logic                 hit_array;
  logic                 hit_status;
  logic [`ARRAY_AW-1:0] word_idx;
  logic                 latch_en;
  logic                 burning;

  assign access     = psel && penable;
  assign wr         = access && pwrite;
  assign rd         = access && !pwrite;
  assign word_idx   = paddr[`ARRAY_AW+1:2];
  assign hit_array  = paddr[`PADDR_W-1];
  assign hit_ctrl   = !hit_array && (paddr[`ARRAY_AW-1:0] == `CTRL_ADDR);
  assign hit_status = !hit_array && (paddr[`ARRAY_AW-1:0] == `STATUS_ADDR);
  assign latch_en   = ctrl[`BIT_LATCH_EN];
  assign pready     = 1'b1;
  assign pslverr    = access && !(hit_array || hit_ctrl || hit_status);
  // power only reaches the array with the high voltage present and modes right
  assign burning    = ctrl[`BIT_PROG_POWER] && latch_en && vpp_high_voltage && special_mode
                      && prom_present_enable;
  assign program_power_on = ctrl[`BIT_PROG_POWER];

  // unimplemented bits dropped; test bits kept but drive nothing
  always_comb begin
    next_ctrl = pwdata[7:0] & `CTRL_WMASK;
    if (!latch_en) begin
      next_ctrl[`BIT_PROG_POWER] = ctrl[`BIT_PROG_POWER];
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
    end else if (wr && hit_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // latches: only filled while latch enable set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_addr  <= '0;
      latch_data  <= 8'h00;
      latch_valid <= 1'b0;
    end else if (!latch_en) begin
      latch_valid <= 1'b0;
    end else if (wr && hit_array && !burning) begin
      latch_addr  <= word_idx;
      latch_data  <= pwdata[7:0];
      latch_valid <= 1'b1;
    end
  end

  // erased array; burning can only pull bits to zero
  initial begin
    for (int i = 0; i < `ARRAY_WORDS; i++)
      mem[i] = `ERASED_BYTE;
  end
  always_ff @(posedge pclk) begin
    if (burning && latch_en && latch_valid)
      mem[latch_addr] <= mem[latch_addr] & latch_data;
  end

  // mode tracking for status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= prom_program_control_pkg::read_mode;
    else if (!latch_en)
      state <= prom_program_control_pkg::read_mode;
    else if (burning)
      state <= prom_program_control_pkg::burn_mode;
    else
      state <= prom_program_control_pkg::latch_mode;
  end

  // read data, registered at the end of the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr[`PADDR_W-1])
        prdata <= latch_en ? 32'h0000_0000
                           : {24'h000000, mem[word_idx]};
      else if (paddr[`ARRAY_AW-1:0] == `CTRL_ADDR)
        prdata <= {24'h000000, ctrl & `CTRL_WMASK};
      else if (paddr[`ARRAY_AW-1:0] == `STATUS_ADDR)
        prdata <= {28'h0000000, latch_valid, burning, state};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // register and bus checks
  property p_reset_clear;
    @(posedge pclk) $rose(presetn) |-> ctrl == `CTRL_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("control not clear");

  property p_power_guard;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_ctrl && !latch_en) |=> $stable(ctrl[`BIT_PROG_POWER]);
  endproperty
  a_power_guard: assert property (p_power_guard) else $error("power written unlatched");

  property p_unimpl_zero;
    @(posedge pclk) disable iff (!presetn)
      (ctrl & ~`CTRL_WMASK) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_no_latch_when_off;
    @(posedge pclk) disable iff (!presetn)
      !latch_en |=> !latch_valid;
  endproperty
  a_no_latch_when_off: assert property (p_no_latch_when_off) else $error("latch while off");

  property p_latch_capture;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_array && latch_en && !burning) |=> latch_valid && latch_data == $past(pwdata[7:0]);
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("latch not captured");

  property p_burn_needs_vpp;
    @(posedge pclk) disable iff (!presetn)
      !vpp_high_voltage |=> mem[$past(latch_addr)] == $past(mem[latch_addr]);
  endproperty
  a_burn_needs_vpp: assert property (p_burn_needs_vpp) else $error("burn without vpp");

  property p_power_out;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_ctrl && latch_en) |=> program_power_on == $past(pwdata[`BIT_PROG_POWER]);
  endproperty
  a_power_out: assert property (p_power_out) else $error("power output wrong");

  property p_read_blocked;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_array && latch_en) |=> prdata == 32'h0;
  endproperty
  a_read_blocked: assert property (p_read_blocked) else $error("array read in latch mode");

  property p_ctrl_store;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_ctrl) |=> (ctrl & `CTRL_STORE_MASK) == ($past(pwdata[7:0]) & `CTRL_STORE_MASK);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control bits not stored");

  property p_ctrl_quiet;
    @(posedge pclk) disable iff (!presetn)
      !(wr && hit_ctrl) |=> $stable(ctrl);
  endproperty
  a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("control changed unwritten");

  property p_power_on_latched;
    @(posedge pclk) disable iff (!presetn)
      $rose(program_power_on) |-> $past(latch_en);
  endproperty
  a_power_on_latched: assert property (p_power_on_latched) else $error("power on unlatched");

  property p_power_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_ctrl && latch_en && !pwdata[`BIT_PROG_POWER]) |=> !program_power_on;
  endproperty
  a_power_clear: assert property (p_power_clear) else $error("power not removed");

  property p_no_burn_unlatched;
    @(posedge pclk) disable iff (!presetn)
      !latch_en |-> !burning;
  endproperty
  a_no_burn_unlatched: assert property (p_no_burn_unlatched) else $error("burn in read mode");

  property p_read_ctrl;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_ctrl) |=> prdata == {24'h000000, $past(ctrl) & `CTRL_WMASK};
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

  property p_read_array;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_array && !latch_en) |=> prdata == {24'h000000, $past(mem[word_idx])};
  endproperty
  a_read_array: assert property (p_read_array) else $error("array read wrong");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_status)
        |=> prdata == {28'h0000000, $past(latch_valid), $past(burning), $past(state)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  // latch checks
  property p_latch_addr_capture;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_array && latch_en && !burning) |=> latch_addr == $past(word_idx);
  endproperty
  a_latch_addr_capture: assert property (p_latch_addr_capture) else $error("address not latched");

  property p_latch_idle;
    @(posedge pclk) disable iff (!presetn)
      (latch_en && !(wr && hit_array)) |=> $stable(latch_data) && $stable(latch_addr);
  endproperty
  a_latch_idle: assert property (p_latch_idle) else $error("latch changed idle");

  property p_latch_hold_off;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_array && !latch_en) |=> $stable(latch_data) && $stable(latch_addr);
  endproperty
  a_latch_hold_off: assert property (p_latch_hold_off) else $error("latch written in read mode");

  property p_latch_burn_freeze;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_array && burning) |=> $stable(latch_data);
  endproperty
  a_latch_burn_freeze: assert property (p_latch_burn_freeze) else $error("latch moved while burning");

  // array checks watch the latched word only
  property p_array_hold;
    @(posedge pclk) disable iff (!presetn)
      !latch_en |=> mem[$past(latch_addr)] == $past(mem[latch_addr]);
  endproperty
  a_array_hold: assert property (p_array_hold) else $error("array changed in read mode");

  property p_burn_clears;
    @(posedge pclk) disable iff (!presetn)
      (burning && latch_valid) |=> mem[$past(latch_addr)] == ($past(mem[latch_addr]) & $past(latch_data));
  endproperty
  a_burn_clears: assert property (p_burn_clears) else $error("burn result wrong");

  property p_reset_state;
    @(posedge pclk) $rose(presetn) |-> !latch_valid && !program_power_on && prdata == 32'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_state_latch;
    @(posedge pclk) disable iff (!presetn)
      (latch_en && !burning) |=> state == prom_program_control_pkg::latch_mode;
  endproperty
  a_state_latch: assert property (p_state_latch) else $error("state not latch");

  property p_state_burn;
    @(posedge pclk) disable iff (!presetn)
      burning |=> state == prom_program_control_pkg::burn_mode;
  endproperty
  a_state_burn: assert property (p_state_burn) else $error("state not burn");

  property p_state_read;
    @(posedge pclk) disable iff (!presetn)
      !latch_en |=> state == prom_program_control_pkg::read_mode;
  endproperty
  a_state_read: assert property (p_state_read) else $error("state not read");

  c_program: cover property (@(posedge pclk) disable iff (!presetn) burning && latch_valid);
  c_latch: cover property (@(posedge pclk) disable iff (!presetn) wr && hit_array && latch_en);
  c_read: cover property (@(posedge pclk) disable iff (!presetn) rd && hit_array && !latch_en);
  c_power_locked: cover property (@(posedge pclk) disable iff (!presetn) wr && hit_ctrl && !latch_en);
  c_restore: cover property (@(posedge pclk) disable iff (!presetn) $fell(latch_en));
endmodule // prom_program_control
`default_nettype wire

// ---- logic/prom_program_control_params.svh ----
// Purpose: constants for the prom programming control block
// Assumes: apb byte addressing, 32-bit data, top address bit selects the array
// Notes: array window and widths fixed
`ifndef PROM_PROGRAM_CONTROL_PARAMS_SVH
`define PROM_PROGRAM_CONTROL_PARAMS_SVH
`define CTRL_INDEX        8'h3b
`define CTRL_ADDR         12'h0ec
`define ARRAY_BASE        12'h800
`define ARRAY_ADDR_BIT    14
`define ARRAY_AW          12
`define ARRAY_WORDS       4096
`define CTRL_RESET        8'h00
`define CTRL_WMASK        8'hb9
`define CTRL_STORE_MASK   8'hb8
`define BIT_MULTI_BYTE    7
`define BIT_LATCH_EN      5
`define BIT_EXTRA_COL     4
`define BIT_EXTRA_ROW     3
`define BIT_PROG_POWER    0
`define ERASED_BYTE       8'hff
`define STATUS_ADDR       12'h0f0
`define PADDR_W           15
`endif

// ---- logic/prom_program_control_pkg.sv ----
// Purpose: types for the prom programming control block
// Assumes: nothing
// Notes: none
package prom_program_control_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {read_mode, latch_mode, burn_mode} prom_state_e;
endpackage

// ---- testbench/prom_program_control_bench.sv ----
// Purpose: self-checking bench for the prom programming control block
// Assumes: zero-wait apb slave, array erased at start of simulation
// Notes: burn held a few cycles only; the block keeps no burn timer
`include "prom_program_control_params.svh"
`timescale 1ns/1ps
`default_nettype none
module prom_program_control_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, program_power_on;
  logic        special_mode, prom_present_enable, vpp_high_voltage;
  logic [14:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  localparam logic [14:0] ctrl = {3'b000, `CTRL_ADDR};
  prom_program_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .special_mode(special_mode), .prom_present_enable(prom_present_enable),
    .vpp_high_voltage(vpp_high_voltage), .program_power_on(program_power_on));
  always #5 pclk = ~pclk;
  task automatic final_report();
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles of the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [14:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // ctx is {vpp, special, present}; vpp never dropped mid-burn
  task automatic burn(input int i, input logic [7:0] d, input logic [2:0] ctx);
    {vpp_high_voltage, special_mode, prom_present_enable} <= ctx;
    apb(1'b1, ctrl, 32'h20);
    apb(1'b1, 15'h4000 + 15'(4 * i), {24'h0, d});
    apb(1'b1, ctrl, 32'h21);
    repeat (8) @(posedge pclk);
    apb(1'b1, ctrl, 32'h20);
    apb(1'b1, ctrl, 32'h00);
    apb(1'b0, 15'h4000 + 15'(4 * i), 32'h0);
  endtask
  task automatic t_reset();
    apb(1'b0, ctrl, 32'h0);
    check("ctrl_reset", rd, 32'h00);
    check("power_reset", {31'h0, program_power_on}, 32'h0);
    apb(1'b0, 15'h4000, 32'h0);
    check("erased", rd, 32'h0000_00ff);
  endtask
  task automatic t_gating();
    {vpp_high_voltage, special_mode, prom_present_enable} <= 3'b111;
    apb(1'b1, ctrl, 32'h01);
    apb(1'b0, ctrl, 32'h0);
    check("power_locked", rd, 32'h00);
    apb(1'b1, 15'h4004, 32'h00);
    apb(1'b1, ctrl, 32'h20);
    apb(1'b1, ctrl, 32'hff);
    apb(1'b0, ctrl, 32'h0);
    check("ctrl_bits", rd, 32'h0000_00b9);
    check("power_on", {31'h0, program_power_on}, 32'h1);
    apb(1'b0, 15'h4004, 32'h0);
    check("latch_read", rd, 32'h0);
    apb(1'b1, ctrl, 32'h20);
    check("power_off", {31'h0, program_power_on}, 32'h0);
    apb(1'b1, ctrl, 32'h00);
    apb(1'b0, 15'h4004, 32'h0);
    check("no_latch_write", rd, 32'h0000_00ff);
  endtask
  task automatic t_program();
    logic [2:0] ctx [4] = '{3'b011, 3'b101, 3'b110, 3'b111};
    logic [7:0] exp [4] = '{8'hff, 8'hff, 8'hff, 8'h5a};
    for (int k = 0; k < 4; k++) begin
      burn(5, 8'h5a, ctx[k]);
      check("burn_gate", rd, {24'h0, exp[k]});
    end
    burn(5, 8'h0f, 3'b111);
    check("clear_only", rd, 32'h0000_000a);
    burn(2, 8'h81, 3'b111);
    check("any_order", rd, 32'h0000_0081);
  endtask
  task automatic t_unmapped();
    apb(1'b0, 15'h0004, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {vpp_high_voltage, special_mode, prom_present_enable} = 3'b000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_gating();
    t_program();
    t_unmapped();
    final_report();
  end
endmodule // prom_program_control_bench
`default_nettype wire
